// ---- hdl/scpc_consts.vh ----
// constants for the system clock prescaler control block
// Overview of operation
// (RQ1) clock out fuse drives clock pin, even in reset; here in reset the pin is high only with select 0
// (RQ2) clock pin carries the divided system clock
// (RQ3) timer oscillator only with RC system clock
// (RQ4) external clock select accepts clock on timer input
// (RQ5) prescaler divides all synchronous clock domains
// (RQ6) division changes glitch free, no faster intermediates
// (RQ7) new rate within T1+T2 to T1+2*T2
// (RQ8) ripple counter on undivided clock, unreadable
// (RQ9) change enable set only with others zero
// (RQ10) change enable clears after four cycles or select write
// (RQ11) rewriting change enable neither restarts nor clears
// (RQ12) software unlocks then writes select within four cycles
// (RQ13) reset select is 0000, or 0011 with div8 fuse
// (RQ14) select accepts any value regardless of fuse
// (RQ15) codes 0..8 give divide 1..256, rest reserved
// (RQ16) reset loads factory trim value
// (RQ17) trim bit 7 selects oscillator range
// (RQ18) trim bits 6..0 tune within range
// (RQ19) software keeps trim under 8.8MHz during writes
// (RQ20) prescale bits 6..4 read zero, ignore writes
`ifndef SCPC_CONSTS_VH
`define SCPC_CONSTS_VH
`define SCPC_ADDR_PRESCALE  8'h61
`define SCPC_ADDR_TRIM      8'h66
`define SCPC_ADDR_ASYNC     8'hb6
`define SCPC_PCE_BIT        7
`define SCPC_ASYNC_EXT_CLOCK_SEL_BIT     6
`define SCPC_RANGE_BIT      7
`define SCPC_DIV_RST_FUSE   4'h3
`define SCPC_DIV_RST_PLAIN  4'h0
`define SCPC_DIV_MAX_CODE   4'h8
`define SCPC_PCE_CYCLES     3'h4
`endif

// ---- hdl/scpc_prescaler.v ----
// system clock prescaler, change unlock, trim and clock out control
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
`include "scpc_consts.vh"
module scpc_prescaler #(
    parameter [7:0] FACTORY_TRIM = 8'h80
) (
    // clock and reset
    input  wire       clk_i,
    input  wire       srst_i,
    // fuses
    input  wire       clock_out_fuse_i,
    input  wire       div8_default_fuse_i,
    // register port
    input  wire [7:0] addr_i,
    input  wire [7:0] wdata_i,
    input  wire       wr_i,
    input  wire       rd_i,
    output reg  [7:0] rdata_o,
    // timer oscillator and crystal clock inputs, selected timer clock output
    input  wire       timer_osc_in_i,
    input  wire       crystal_clk_i,
    output wire       timer_clk_o,
    // system clock enable and clock pin
    output reg        sys_clk_en_o,
    output reg        sysclk_out_pin_o,
    output wire       sysclk_out_pin_oe_o,
    // oscillator trim
    output wire       trim_range_bit_o,
    output wire [6:0] trim_tune_o
);

    reg  [3:0] clock_div_select;
    reg        div_change_enable;
    reg  [2:0] pce_count;
    reg  [7:0] rc_oscillator_trim;
    reg        async_ext_clock_sel;
    reg  [7:0] ripple;
    reg  [3:0] active_sel;
    reg        pending;
    wire       wr_pre;
    wire       tick;
    wire       sel_change;

    // divider tap: true when prescaler crosses a period of 2**sel
    function tap;
        input [3:0] sel;
        input [7:0] cnt;
        integer     k;
        begin
            tap = 1'b1;
            for (k = 0; k < 8; k = k + 1) begin
                if (k < sel && cnt[k] == 1'b0) begin
                    tap = 1'b0;
                end
            end
        end
    endfunction

    assign wr_pre     = wr_i && (addr_i == `SCPC_ADDR_PRESCALE);
    // write to select field is only taken inside the unlock window
    assign sel_change = wr_pre && !wdata_i[`SCPC_PCE_BIT] && div_change_enable; // [RQ12]

    // prescale register and change enable window
    always @(posedge clk_i) begin
        if (srst_i) begin
            clock_div_select  <= div8_default_fuse_i ? `SCPC_DIV_RST_FUSE
                                                      : `SCPC_DIV_RST_PLAIN; // [RQ13]
            div_change_enable <= 1'b0;
            pce_count         <= 3'h0;
        end else begin
            if (sel_change) begin
                clock_div_select  <= wdata_i[3:0]; // [RQ14]
                div_change_enable <= 1'b0; // [RQ10]
                pce_count         <= 3'h0;
            end else if (wr_pre && wdata_i == 8'h80 && !div_change_enable) begin
                div_change_enable <= 1'b1; // [RQ9]
                pce_count         <= 3'h0;
            end else if (div_change_enable) begin
                // rewrite during window leaves count running [RQ11]
                if (pce_count == `SCPC_PCE_CYCLES - 3'h1) begin
                    div_change_enable <= 1'b0; // [RQ10]
                    pce_count         <= 3'h0;
                end else begin
                    pce_count <= pce_count + 3'h1;
                end
            end
        end
    end

    // trim and async select registers
    always @(posedge clk_i) begin
        if (srst_i) begin
            rc_oscillator_trim  <= FACTORY_TRIM; // [RQ16]
            async_ext_clock_sel <= 1'b0;
        end else if (wr_i) begin
            if (addr_i == `SCPC_ADDR_TRIM) begin
                rc_oscillator_trim <= wdata_i;
            end
            if (addr_i == `SCPC_ADDR_ASYNC) begin
                async_ext_clock_sel <= wdata_i[`SCPC_ASYNC_EXT_CLOCK_SEL_BIT];
            end
        end
    end

    assign trim_range_bit_o = rc_oscillator_trim[`SCPC_RANGE_BIT]; // [RQ17]
    assign trim_tune_o      = rc_oscillator_trim[6:0]; // [RQ18]
    // external clock on timer input replaces crystal
    assign timer_clk_o = async_ext_clock_sel ? timer_osc_in_i : crystal_clk_i; // [RQ4]

    // free running counter on undivided clock, not readable [RQ8]
    always @(posedge clk_i) begin
        if (srst_i) begin
            ripple <= 8'h00;
        end else begin
            ripple <= ripple + 8'h01;
        end
    end

    // reserved codes behave as divide by 256
    assign tick = tap((active_sel > `SCPC_DIV_MAX_CODE) ? `SCPC_DIV_MAX_CODE
                                                        : active_sel, ripple); // [RQ15]

    // switch divider only on an old-rate edge, then new rate [RQ6] [RQ7]
    always @(posedge clk_i) begin
        if (srst_i) begin
            active_sel   <= div8_default_fuse_i ? `SCPC_DIV_RST_FUSE
                                                 : `SCPC_DIV_RST_PLAIN;
            pending      <= 1'b0;
            sys_clk_en_o <= 1'b0;
        end else begin
            sys_clk_en_o <= tick; // [RQ5]
            if (sel_change) begin
                pending <= 1'b1;
            end else if (pending && tick) begin
                active_sel <= clock_div_select;
                pending    <= 1'b0;
            end
        end
    end

    // clock pin shows divided clock; in reset ripple is held, so the pin is high only with select 0 [RQ1] [RQ2]
    always @(posedge clk_i) begin
        sysclk_out_pin_o <= clock_out_fuse_i & tick;
    end
    assign sysclk_out_pin_oe_o = clock_out_fuse_i; // [RQ1]

    // read data one cycle after strobe
    always @(posedge clk_i) begin
        if (srst_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            case (addr_i)
                `SCPC_ADDR_PRESCALE: rdata_o <= {div_change_enable, 3'b000,
                                                 clock_div_select}; // [RQ20]
                `SCPC_ADDR_TRIM:     rdata_o <= rc_oscillator_trim;
                `SCPC_ADDR_ASYNC:    rdata_o <= {1'b0, async_ext_clock_sel, 6'h00};
                default:             rdata_o <= 8'h00;
            endcase
        end else begin
            rdata_o <= 8'h00;
        end
    end

endmodule // scpc_prescaler

// ---- testbench/scpc_asserts.sv ----
// port assertions for the prescaler control block
`timescale 1ns/1ps
module scpc_asserts (
    input wire       clk_i,
    input wire       srst_i,
    input wire       clock_out_fuse_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire       wr_i,
    input wire       rd_i,
    input wire [7:0] rdata_o,
    input wire       sysclk_out_pin_oe_o,
    input wire       trim_range_bit_o,
    input wire [6:0] trim_tune_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    sequence unlock; wr_i && addr_i == 8'h61 && wdata_i == 8'h80; endsequence
    sequence quiet_unlock; (!wr_i) [*4] ##1 unlock; endsequence
    sequence rd_next; !wr_i ##1 rd_i && addr_i == 8'h61; endsequence
    pin_enable_a: assert property (
        sysclk_out_pin_oe_o == clock_out_fuse_i) else $error("pin enable wrong");
    pce_open_a: assert property (
        quiet_unlock ##1 rd_next |=> rdata_o[7]) else $error("enable not set");
    pce_keep_a: assert property (
        quiet_unlock ##1 (!wr_i) [*3] ##1 unlock ##1 rd_next |=> !rdata_o[7])
        else $error("enable window restarted");
    pce_guard_a: assert property (
        (!wr_i) [*4] ##1 wr_i && addr_i == 8'h61 && wdata_i > 8'h80 ##1 rd_next
        |=> !rdata_o[7]) else $error("enable set by mixed write");
    sel_write_a: assert property (
        quiet_unlock ##1 !wr_i ##1 wr_i && addr_i == 8'h61 && !wdata_i[7] ##1 rd_next
        |=> rdata_o == ($past(wdata_i, 3) & 8'h0f)) else $error("select not taken");
    hole_read_a: assert property (
        rd_i && addr_i == 8'h61 |=> rdata_o[6:4] == 3'h0) else $error("unused bits set");
    range_write_a: assert property (
        wr_i && addr_i == 8'h66 |=> {trim_range_bit_o, trim_tune_o} == $past(wdata_i))
        else $error("trim not taken");
    tune_write_a: assert property (
        wr_i && addr_i == 8'h66 |=> trim_tune_o == ($past(wdata_i) & 8'h7f))
        else $error("tune not taken");
endmodule // scpc_asserts

// ---- testbench/tb_system_clock_prescaler_ctrl.sv ----
// self-checking bench for the prescaler control block
`timescale 1ns/1ps
module tb_system_clock_prescaler_ctrl;
    logic       clk_i = 0, srst_i = 1, d8 = 1, wr_i = 0, rd_i = 0, cko = 1;
    logic [7:0] addr_i = 0, wdata_i = 0;
    wire  [7:0] rdata_o;
    wire  [6:0] tune;
    wire        tclk, en, pin, oe, rng;
    int         errors = 0, n_compared = 0;
    scpc_prescaler dut_u (.clk_i, .srst_i, .clock_out_fuse_i(cko), .div8_default_fuse_i(d8),
        .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .timer_osc_in_i(1'b1), .crystal_clk_i(1'b0),
        .timer_clk_o(tclk), .sys_clk_en_o(en), .sysclk_out_pin_o(pin),
        .sysclk_out_pin_oe_o(oe), .trim_range_bit_o(rng), .trim_tune_o(tune));
    initial forever #5 clk_i = ~clk_i;
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk_i);
        {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
        @(posedge clk_i);
        wr_i <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clk_i);
        {rd_i, addr_i} <= {1'b1, a};
        @(posedge clk_i);
        rd_i <= 0;
        #1 chk("rdata", e, rdata_o);
    endtask
    // time between divided clock pulses
    task automatic gap(int e);
        int n = 0;
        @(negedge clk_i);
        while (en !== 1'b1) @(negedge clk_i);
        chk("pin", 1, pin);
        do begin
            @(negedge clk_i);
            n++;
        end while (en !== 1'b1 && n < 600);
        chk("period", e, n);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        srst_i <= 0;
        rd(8'h61, 8'h03);
        rd(8'h66, 8'h80);
        rd(8'h20, 8'h00);
        wr(8'h61, 8'h8f);
        rd(8'h61, 8'h03);
        repeat (5) @(posedge clk_i);
        wr(8'h61, 8'h80);
        rd(8'h61, 8'h83);
        wr(8'h61, 8'h80);
        rd(8'h61, 8'h03);
        wr(8'h61, 8'h05);
        rd(8'h61, 8'h03);
        for (int c = 0; c < 10; c++) begin
            repeat (5) @(posedge clk_i);
            wr(8'h61, 8'h80);
            wr(8'h61, 8'(c));
            rd(8'h61, 8'(c));
            repeat (600) @(posedge clk_i);
            if (c < 9) gap(1 << c);
        end
        for (int i = 0; i < 2; i++) begin
            wr(8'h66, i ? 8'h80 : 8'h7f); // no flash write runs here
            rd(8'h66, i ? 8'h80 : 8'h7f);
            chk("range", i, rng);
            chk("tune", i ? 16'h0000 : 16'h007f, tune);
        end
        chk("tclk", 0, tclk);
        wr(8'hb6, 8'h40);
        #1 chk("tclk", 1, tclk);
        @(posedge clk_i);
        cko <= 0;
        repeat (2) @(posedge clk_i);
        #1 chk("oe", 0, oe);
        chk("pin", 0, pin);
        @(posedge clk_i);
        cko <= 1;
        @(posedge clk_i);
        {srst_i, d8} <= 2'b10;
        repeat (10) @(posedge clk_i);
        @(negedge clk_i);
        chk("oe", 1, oe);
        chk("pin", 1, pin);
        @(posedge clk_i);
        srst_i <= 0;
        rd(8'h61, 8'h00);
        conclude;
    end
    initial begin
        repeat (30000) @(posedge clk_i);
        errors++;
        conclude;
    end
endmodule // tb_system_clock_prescaler_ctrl
bind scpc_prescaler scpc_asserts chk_u (.clk_i, .srst_i, .clock_out_fuse_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .sysclk_out_pin_oe_o, .trim_range_bit_o, .trim_tune_o);
